// ==== logic/pssm_cfg.svh ====
`ifndef PSSM_CFG_SVH
`define PSSM_CFG_SVH
// register byte offsets
`define PSSM_OFF_CTRL 12'h000
`define PSSM_OFF_MAP 12'h004
`define PSSM_OFF_PART 12'h008
`define PSSM_OFF_SDEF 12'h00C
`define PSSM_OFF_SSTART 12'h010
`define PSSM_OFF_STAT 12'h014
// control register fields
`define PSSM_CTRL_W 7
`define PSSM_CTRL_RST 7'h41
`define PSSM_B_SLEEP 0
`define PSSM_B_PARTIAL 1
`define PSSM_B_SCROLL 2
`define PSSM_B_TEAR_EN 3
`define PSSM_B_TEAR_MODE 4
`define PSSM_B_GSEL_LO 5
`define PSSM_B_GSEL_HI 6
// memory access control parameter fields
`define PSSM_MAP_RST 8'h00
`define PSSM_B_RGB 3
`define PSSM_B_SDIR 4
`define PSSM_B_CMIR 6
`define PSSM_B_RMIR 7
// field slices of the byte-packed registers
`define PSSM_F_B0 7:0
`define PSSM_F_B1 15:8
`define PSSM_F_B2 23:16
`define PSSM_F_STAT_VBL 8
`define PSSM_F_STAT_HBL 9
`define PSSM_F_STAT_TEAR 10
// panel geometry
`define PSSM_LINES_240 8'hF0
`define PSSM_LINES_220 8'hDC
`define PSSM_LINES_208 8'hD0
`define PSSM_COL_MAX 8'hAF
`define PSSM_ROW_MAX 8'hEF
// line timing
`define PSSM_CLK_NS 5
`define PSSM_T_HLOW_NS 40000
`define PSSM_T_HHIGH_NS 25000
`define PSSM_T_VHIGH_NS 1000000
`endif

// ==== logic/pssm_pkg.sv ====
package pssm_pkg;
  // bus data word
  typedef logic [31:0] pssm_word_t;
  // line index or row address
  typedef logic [7:0] pssm_line_t;
  // line phase of the scan timer
  typedef enum logic [1:0] {TS_DISP, TS_HBLK, TS_VBLK} pssm_tstate_t;
  // gate count select {hi, lo}
  typedef enum logic [1:0] {GS_208, GS_220, GS_240, GS_RSVD} pssm_gsel_t;
endpackage

// ==== logic/pssm_scan_if.sv ====
`timescale 1ns/1ps
interface pssm_scan_if;
  import pssm_pkg::*;
  pssm_line_t n_lines; // active gate rows
  logic scan_direction; // reverse scan order
  logic row_mirror; // reverse memory rows
  logic scroll_en; // vertical scroll on
  logic partial_en; // partial display on
  pssm_line_t top_fixed_area;
  pssm_line_t scroll_area_height;
  pssm_line_t bottom_fixed_area;
  pssm_line_t scroll_start_value;
  pssm_line_t partial_start_line;
  pssm_line_t partial_end_line;
  pssm_line_t line_idx; // line in scan order
  logic line_go; // first cycle of an active line
  logic vblank; // vertical blanking
  logic hblank; // horizontal blanking
  pssm_line_t gate_row; // gate row being driven
  pssm_line_t fm_row; // frame memory row feeding it
  logic visible; // row shown: partial display off or row inside the window
  modport tim (input n_lines, output line_idx, line_go, vblank, hblank);
  modport map (input n_lines, scan_direction, row_mirror, scroll_en, partial_en,
    top_fixed_area, scroll_area_height, bottom_fixed_area, scroll_start_value,
    partial_start_line, partial_end_line, line_idx, output gate_row, fm_row, visible);
  modport ctl (output n_lines, scan_direction, row_mirror, scroll_en, partial_en,
    top_fixed_area, scroll_area_height, bottom_fixed_area, scroll_start_value,
    partial_start_line, partial_end_line,
    input line_idx, line_go, vblank, hblank, gate_row, fm_row, visible);
endinterface

// ==== logic/pssm_timing.sv ====
`timescale 1ns/1ps
module pssm_timing #(
  parameter int H_LOW_CYC = 8000,
  parameter int H_HIGH_CYC = 5000,
  parameter int VBL_LINES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  pssm_scan_if.tim s
);
  import pssm_pkg::*;
  localparam logic [15:0] LOW_M1 = 16'(H_LOW_CYC - 1);
  localparam logic [15:0] HIGH_M1 = 16'(H_HIGH_CYC - 1);
  localparam logic [15:0] LINE_M1 = 16'(H_LOW_CYC + H_HIGH_CYC - 1);
  localparam logic [8:0] VBL = 9'(VBL_LINES);
  pssm_tstate_t state_reg, state_next; // line phase
  logic [15:0] hcnt_reg; // cycle within the phase
  logic [8:0] vcnt_reg, vcnt_next; // line within the field
  // phase length: display part, blank part, or a whole blank line
  wire [15:0] len_m1 = (state_reg == TS_DISP) ? LOW_M1 :
    (state_reg == TS_HBLK) ? HIGH_M1 : LINE_M1;
  wire phase_end = hcnt_reg == len_m1;
  wire [8:0] n9 = {1'b0, s.n_lines};
  // phase sequencing; one counter set drives gates and sync alike
  always_comb begin
    state_next = state_reg;
    vcnt_next = vcnt_reg;
    case (state_reg)
      TS_DISP: if (phase_end) state_next = TS_HBLK;
      TS_HBLK: if (phase_end) begin
        vcnt_next = vcnt_reg + 9'h001;
        state_next = (vcnt_reg + 9'h001 >= n9) ? TS_VBLK : TS_DISP;
      end
      TS_VBLK: if (phase_end) begin
        vcnt_next = (vcnt_reg >= n9 + VBL - 9'h001) ? 9'h000 : vcnt_reg + 9'h001;
        state_next = (vcnt_reg >= n9 + VBL - 9'h001) ? TS_DISP : TS_VBLK;
      end
      default: state_next = TS_DISP;
    endcase
  end
  // timer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= TS_DISP;
      hcnt_reg <= 16'h0000;
      vcnt_reg <= 9'h000;
    end else begin
      state_reg <= state_next;
      hcnt_reg <= phase_end ? 16'h0000 : hcnt_reg + 16'h0001;
      vcnt_reg <= vcnt_next;
    end
  end
  assign s.line_idx = vcnt_reg[7:0];
  assign s.line_go = (state_reg == TS_DISP) && (hcnt_reg == 16'h0000);
  assign s.vblank = state_reg == TS_VBLK;
  assign s.hblank = state_reg == TS_HBLK;
  // helper: length of the last run of horizontal blanking
  logic [15:0] hrun_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hrun_reg <= 16'h0000;
    else hrun_reg <= s.hblank ? hrun_reg + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_hblank_len: assert property ($fell(s.hblank) |-> hrun_reg == 16'(H_HIGH_CYC))
    else $error("horizontal blank length wrong");
  a_line_aligned: assert property (s.line_go |-> s.line_idx < s.n_lines && !s.vblank)
    else $error("line start outside active field");
  a_vblank_end: assert property ($fell(s.vblank) |-> $past(vcnt_reg) >= n9 + VBL - 9'h001)
    else $error("vertical blank ended early");
endmodule

// ==== logic/pssm_rowmap.sv ====
`timescale 1ns/1ps
module pssm_rowmap (
  pssm_scan_if.map s
);
  import pssm_pkg::*;
  wire [7:0] last = s.n_lines - 8'h01; // last active row
  // gate row from scan order
  wire [7:0] gate = s.scan_direction ? last - s.line_idx : s.line_idx;
  // fixed areas trade places when scanning reversed
  wire [7:0] top = s.scan_direction ? s.bottom_fixed_area : s.top_fixed_area;
  wire [8:0] scr_end = {1'b0, top} + {1'b0, s.scroll_area_height};
  wire in_scroll = s.scroll_en && (gate >= top) && ({1'b0, gate} < scr_end);
  // scroll rows start at the start value and wrap inside the area
  wire [8:0] raw = {1'b0, s.scroll_start_value} + {1'b0, gate} - {1'b0, top};
  wire [8:0] wrapped = (raw >= scr_end) ? raw - {1'b0, s.scroll_area_height} : raw;
  wire [7:0] disp = in_scroll ? wrapped[7:0] : gate;
  // partial window may wrap past the last row
  wire ordered = s.partial_start_line <= s.partial_end_line;
  wire in_win = ordered ?
    (gate >= s.partial_start_line && gate <= s.partial_end_line) :
    (gate >= s.partial_start_line || gate <= s.partial_end_line);
  assign s.gate_row = gate;
  assign s.fm_row = s.row_mirror ? last - disp : disp;
  assign s.visible = !s.partial_en || in_win;
endmodule

// ==== logic/pssm_top.sv ====
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "pssm_cfg.svh"
// Contract
// - gate select yields 240, 220 or 208 rows
// - column mirror reverses column 0..175 order
// - row mirror reverses memory rows per panel
// - scan direction reverses gate scan order
// - colour order swaps red and blue outputs
// - display columns 00h-AFh, rows 00h-EFh
// - first memory location feeds top-left dot
// - partial window from start and end lines
// - scroll definition and start address commands
// - reversed scan swaps top and bottom areas
// - sync output enabled, disabled, mode selected
// - mode 1 high only during vertical blank
// - mode 2 adds pulse per line
// - sleep holds sync output low
// - sync phases meet minimum durations
module pssm_top #(
  parameter int H_LOW_CYC = (`PSSM_T_HLOW_NS + `PSSM_CLK_NS - 1) / `PSSM_CLK_NS,
  parameter int H_HIGH_CYC = (`PSSM_T_HHIGH_NS + `PSSM_CLK_NS - 1) / `PSSM_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire pssm_pkg::pssm_word_t pwdata,
  output pssm_pkg::pssm_word_t prdata,
  output logic pready,
  output logic pslverr,
  output logic tearing_sync_out,
  output pssm_pkg::pssm_line_t scan_addr,
  output pssm_pkg::pssm_line_t row_addr,
  output pssm_pkg::pssm_line_t column_addr,
  output logic pixel_valid,
  output logic line_visible,
  output logic rgb_swap,
  output pssm_pkg::pssm_line_t gate_lines
);
  import pssm_pkg::*;

  // blank lines covering the vertical high time
  localparam int LINE_NS = `PSSM_T_HLOW_NS + `PSSM_T_HHIGH_NS;
  localparam int VBL_LINES = (`PSSM_T_VHIGH_NS + LINE_NS - 1) / LINE_NS;

  // software visible registers
  logic [`PSSM_CTRL_W-1:0] ctrl_reg; // mode and enable bits
  logic [7:0] memory_access_control_param_reg; // mapping flags
  pssm_line_t partial_start_line_reg;
  pssm_line_t partial_end_line_reg;
  pssm_line_t top_fixed_area_reg;
  pssm_line_t scroll_area_height_reg;
  pssm_line_t bottom_fixed_area_reg;
  pssm_line_t scroll_start_value_reg;

  // bus response and output flops
  pssm_word_t prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic tear_reg;
  pssm_line_t scan_addr_reg;
  pssm_line_t row_addr_reg;
  pssm_line_t column_addr_reg;
  logic pixel_valid_reg;
  logic line_visible_reg;
  logic rgb_swap_reg;
  pssm_line_t gate_lines_reg;

  // column sweep state
  logic col_run_reg;
  pssm_line_t col_cnt_reg;

  pssm_scan_if s ();

  // field views of the control and mapping flag registers
  wire sleep_in = ctrl_reg[`PSSM_B_SLEEP];
  wire tear_en = ctrl_reg[`PSSM_B_TEAR_EN];
  wire tear_mode2 = ctrl_reg[`PSSM_B_TEAR_MODE];
  wire gate_count_sel_hi = ctrl_reg[`PSSM_B_GSEL_HI];
  wire gate_count_sel_lo = ctrl_reg[`PSSM_B_GSEL_LO];
  wire column_mirror = memory_access_control_param_reg[`PSSM_B_CMIR];
  wire colour_order = memory_access_control_param_reg[`PSSM_B_RGB];
  wire scan_direction = memory_access_control_param_reg[`PSSM_B_SDIR];
  wire row_mirror = memory_access_control_param_reg[`PSSM_B_RMIR];

  // active row count from the gate select pair
  wire pssm_gsel_t gsel = pssm_gsel_t'({gate_count_sel_hi, gate_count_sel_lo});
  wire pssm_line_t n_lines = (gsel == GS_240) ? `PSSM_LINES_240 :
    (gsel == GS_220) ? `PSSM_LINES_220 : `PSSM_LINES_208;

  // configuration towards the timer and row mapper
  assign s.n_lines = n_lines;
  assign s.scan_direction = scan_direction;
  assign s.row_mirror = row_mirror;
  assign s.scroll_en = ctrl_reg[`PSSM_B_SCROLL];
  assign s.partial_en = ctrl_reg[`PSSM_B_PARTIAL];
  assign s.top_fixed_area = top_fixed_area_reg;
  assign s.scroll_area_height = scroll_area_height_reg;
  assign s.bottom_fixed_area = bottom_fixed_area_reg;
  assign s.scroll_start_value = scroll_start_value_reg;
  assign s.partial_start_line = partial_start_line_reg;
  assign s.partial_end_line = partial_end_line_reg;

  // line and field timer
  pssm_timing #(
    .H_LOW_CYC(H_LOW_CYC),
    .H_HIGH_CYC(H_HIGH_CYC),
    .VBL_LINES(VBL_LINES)
  ) u_timing (
    .pclk(pclk),
    .presetn(presetn),
    .s(s.tim)
  );

  // row mapping for scroll, mirror and partial window
  pssm_rowmap u_rowmap (
    .s(s.map)
  );

  // bus decode
  wire setup = psel && !penable;
  wire hit_ctrl = paddr == `PSSM_OFF_CTRL;
  wire hit_map = paddr == `PSSM_OFF_MAP;
  wire hit_part = paddr == `PSSM_OFF_PART;
  wire hit_sdef = paddr == `PSSM_OFF_SDEF;
  wire hit_sstart = paddr == `PSSM_OFF_SSTART;
  wire hit_stat = paddr == `PSSM_OFF_STAT;
  wire mapped = hit_ctrl || hit_map || hit_part || hit_sdef || hit_sstart || hit_stat;
  // a write lands only at the completing access edge
  wire wr_go = psel && penable && pready_reg && pwrite;

  // status word shows the scan state
  wire pssm_word_t stat_word = {8'h00, n_lines, 5'h00, tear_reg, s.hblank,
    s.vblank, s.line_idx};
  // read data selection; unused bits read zero
  wire pssm_word_t rd_mux =
    hit_ctrl ? {25'h0000000, ctrl_reg} :
    hit_map ? {24'h000000, memory_access_control_param_reg} :
    hit_part ? {16'h0000, partial_end_line_reg, partial_start_line_reg} :
    hit_sdef ? {8'h00, bottom_fixed_area_reg, scroll_area_height_reg,
      top_fixed_area_reg} :
    hit_sstart ? {24'h000000, scroll_start_value_reg} :
    hit_stat ? stat_word : 32'h00000000;

  // zero wait response: ready in the access phase after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // control and mapping flag registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PSSM_CTRL_RST;
      memory_access_control_param_reg <= `PSSM_MAP_RST;
    end else begin
      if (wr_go && hit_ctrl) ctrl_reg <= pwdata[`PSSM_CTRL_W-1:0];
      if (wr_go && hit_map) memory_access_control_param_reg <= pwdata[`PSSM_F_B0];
    end
  end

  // partial window and scroll definition registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partial_start_line_reg <= 8'h00;
      partial_end_line_reg <= `PSSM_ROW_MAX;
      top_fixed_area_reg <= 8'h00;
      scroll_area_height_reg <= `PSSM_LINES_240;
      bottom_fixed_area_reg <= 8'h00;
      scroll_start_value_reg <= 8'h00;
    end else begin
      // 8-bit start and end lines
      if (wr_go && hit_part) begin
        partial_start_line_reg <= pwdata[`PSSM_F_B0];
        partial_end_line_reg <= pwdata[`PSSM_F_B1];
      end
      // scroll definition: top, scroll and bottom heights
      if (wr_go && hit_sdef) begin
        top_fixed_area_reg <= pwdata[`PSSM_F_B0];
        scroll_area_height_reg <= pwdata[`PSSM_F_B1];
        bottom_fixed_area_reg <= pwdata[`PSSM_F_B2];
      end
      // scroll start address
      if (wr_go && hit_sstart) scroll_start_value_reg <= pwdata[`PSSM_F_B0];
    end
  end

  // column sweep of one line, 176 pixels from address 0
  wire sweep_start = s.line_go && s.visible;
  wire sweep_last = col_cnt_reg == `PSSM_COL_MAX;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_run_reg <= 1'b0;
      col_cnt_reg <= 8'h00;
    end else if (sweep_start) begin
      col_run_reg <= 1'b1;
      col_cnt_reg <= 8'h00;
    end else begin
      col_run_reg <= col_run_reg && !sweep_last;
      col_cnt_reg <= col_run_reg ? col_cnt_reg + 8'h01 : col_cnt_reg;
    end
  end

  // column address order under the mirror flag
  wire pssm_line_t col_map = column_mirror ? `PSSM_COL_MAX - col_cnt_reg : col_cnt_reg;

  // sync level: mode 1 vertical only, mode 2 adds per line blank
  wire tear_raw = tear_mode2 ? (s.vblank || s.hblank) : s.vblank;
  wire tear_next = tear_en && !sleep_in && tear_raw;

  // pixel, column address and colour order outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_valid_reg <= 1'b0;
      column_addr_reg <= 8'h00;
      rgb_swap_reg <= 1'b0;
    end else begin
      pixel_valid_reg <= col_run_reg;
      column_addr_reg <= col_map;
      rgb_swap_reg <= colour_order;
    end
  end

  // row outputs latched at each line start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_addr_reg <= 8'h00;
      row_addr_reg <= 8'h00;
      line_visible_reg <= 1'b0;
    end else if (s.line_go) begin
      scan_addr_reg <= s.gate_row;
      row_addr_reg <= s.fm_row;
      line_visible_reg <= s.visible;
    end
  end

  // sync output and row count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tear_reg <= 1'b0;
      gate_lines_reg <= `PSSM_LINES_240;
    end else begin
      tear_reg <= tear_next;
      gate_lines_reg <= n_lines;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tearing_sync_out = tear_reg;
  assign scan_addr = scan_addr_reg;
  assign row_addr = row_addr_reg;
  assign column_addr = column_addr_reg;
  assign pixel_valid = pixel_valid_reg;
  assign line_visible = line_visible_reg;
  assign rgb_swap = rgb_swap_reg;
  assign gate_lines = gate_lines_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // line start with mirror state taken at that cycle only
  sequence line_fwd;
    sweep_start && !column_mirror;
  endsequence
  sequence line_rev;
    sweep_start && column_mirror;
  endsequence
  sequence sweep_out(logic [7:0] first, logic [7:0] last);
    ##2 pixel_valid_reg && column_addr_reg == first ##175 column_addr_reg == last
      ##1 !pixel_valid_reg;
  endsequence

  a_gate_count_map: assert property (gsel == GS_220 |=> gate_lines_reg == `PSSM_LINES_220)
    else $error("220 row select not applied");
  a_gate_count_208: assert property (gsel == GS_208 |=> gate_lines_reg == `PSSM_LINES_208)
    else $error("208 row select not applied");
  a_col_order_fwd: assert property (line_fwd |-> sweep_out(8'h00, `PSSM_COL_MAX))
    else $error("column sweep order wrong");
  a_col_order_rev: assert property (line_rev |-> sweep_out(`PSSM_COL_MAX, 8'h00))
    else $error("mirrored column sweep wrong");
  a_row_mirror_top: assert property (s.line_go && s.line_idx == 8'h00 && row_mirror &&
    !scan_direction && !s.scroll_en |=> row_addr_reg == gate_lines_reg - 8'h01)
    else $error("mirrored first row wrong");
  a_scan_reverse: assert property (s.line_go && s.line_idx == 8'h00 && scan_direction
    |=> scan_addr_reg == n_lines - 8'h01)
    else $error("reverse scan does not start at last row");
  a_first_dot: assert property (s.line_go && s.line_idx == 8'h00 && !scan_direction &&
    !row_mirror && !s.scroll_en |=> row_addr_reg == 8'h00)
    else $error("top row not fed from first memory row");
  a_colour_swap: assert property ($changed(colour_order) |=> rgb_swap_reg == $past(colour_order))
    else $error("colour order not applied");
  a_partial_hide: assert property (s.line_go && !s.visible |=> !line_visible_reg
    ##1 !pixel_valid_reg[*2])
    else $error("line outside partial window shown");
  a_scroll_entry: assert property (s.line_go && s.scroll_en && !scan_direction &&
    !row_mirror && s.gate_row == top_fixed_area_reg && scroll_area_height_reg != 8'h00
    |=> row_addr_reg == scroll_start_value_reg)
    else $error("scroll area does not start at start value");
  a_tear_disabled: assert property (!tear_en |=> !tear_reg)
    else $error("sync output active while disabled");
  a_tear_sleep: assert property (sleep_in |=> !tear_reg)
    else $error("sync output high in sleep");
  a_tear_mode1: assert property (tear_en && !tear_mode2 && !sleep_in |=>
    tear_reg == $past(s.vblank))
    else $error("mode 1 sync does not follow vertical blank");
  a_tear_mode2: assert property (tear_en && tear_mode2 && !sleep_in && s.hblank |=>
    tear_reg)
    else $error("mode 2 sync misses line pulse");
  a_apb_ready: assert property (setup |=> pready_reg ##1 !pready_reg)
    else $error("bus ready not a single access cycle");

  // row count, bus refusal, scan order, mode 2 vertical sync, register write and visibility latch checks
  a_gate_count_240: assert property (gsel == GS_240 |=> gate_lines_reg == `PSSM_LINES_240)
    else $error("240 row select not applied");
  a_bus_error: assert property (setup && !mapped |=> pslverr_reg && pready_reg)
    else $error("unmapped access not refused");
  a_scan_forward: assert property (s.line_go && !scan_direction |=>
    scan_addr_reg == $past(s.line_idx))
    else $error("forward scan row wrong");
  a_tear_mode2_vbl: assert property (tear_en && tear_mode2 && !sleep_in && s.vblank |=>
    tear_reg)
    else $error("mode 2 sync misses vertical pulse");
  a_ctrl_write: assert property (wr_go && hit_ctrl |=>
    ctrl_reg == $past(pwdata[`PSSM_CTRL_W-1:0]))
    else $error("control write not applied");
  a_vis_latch: assert property (s.line_go |=> line_visible_reg == $past(s.visible))
    else $error("line visibility not latched");
endmodule

// ==== tb/pssm_host_model.sv ====
`timescale 1ns/1ps
// host side: watches the panel sync and decides when frame memory may be written
module pssm_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sync_in, // panel sync from the driver
  input wire logic slow_host, // host writes slower than the panel reads
  output logic write_go, // host may write frame memory now
  output logic [15:0] pulse_cnt // sync rising edges seen
);
  logic sync_q; // sync one cycle back
  wire sync_rise = sync_in & ~sync_q; // start of any sync pulse
  wire sync_fall = ~sync_in & sync_q; // end of any sync pulse
  // count pulses and pace the frame memory writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 1'h0;
      write_go <= 1'h0;
      pulse_cnt <= 16'h0000;
    end else begin
      sync_q <= sync_in;
      if (sync_rise)
        pulse_cnt <= pulse_cnt + 16'h0001;
      if (!slow_host)
        write_go <= sync_in;
      else if (sync_fall)
        write_go <= 1'h1;
    end
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import pssm_pkg::*;
  // one register access and what it should give
  typedef struct packed {
    logic we;
    logic [11:0] a;
    pssm_word_t d;
    pssm_word_t x;
    logic e;
    pssm_line_t g;
  } pssm_row_t;
  logic pclk, presetn, psel, penable, pwrite, slow_host;
  logic [11:0] paddr;
  pssm_word_t pwdata, prdata;
  logic pready, pslverr, tearing_sync_out, pixel_valid, line_visible, rgb_swap, pv_q;
  pssm_line_t scan_addr, row_addr, column_addr, gate_lines;
  logic [15:0] pulse_cnt; // sync pulses counted by the host
  logic host_go; // host may write frame memory
  int error_cnt = 0;
  int total_checks = 0;
  int lcnt = 0; // visible lines seen since reset
  // reads, refusals and gate count after each access
  pssm_row_t rows [13] = '{
    '{1'h0, 12'h000, 32'h0, 32'h41, 1'h0, 8'hF0}, '{1'h0, 12'h004, 32'h0, 32'h0, 1'h0, 8'hF0},
    '{1'h0, 12'h008, 32'h0, 32'hEF00, 1'h0, 8'hF0}, '{1'h0, 12'h00C, 32'h0, 32'hF000, 1'h0, 8'hF0},
    '{1'h0, 12'h002, 32'h0, 32'h0, 1'h1, 8'hF0}, '{1'h1, 12'h018, 32'hFF, 32'h0, 1'h1, 8'hF0},
    '{1'h1, 12'h014, 32'h0, 32'h0, 1'h0, 8'hF0}, '{1'h1, 12'h010, 32'hFFFFFFFF, 32'h0, 1'h0, 8'hF0},
    '{1'h0, 12'h010, 32'h0, 32'hFF, 1'h0, 8'hF0}, '{1'h1, 12'h000, 32'h01, 32'h0, 1'h0, 8'hD0},
    '{1'h1, 12'h000, 32'h21, 32'h0, 1'h0, 8'hDC}, '{1'h1, 12'h000, 32'h61, 32'h0, 1'h0, 8'hD0},
    '{1'h1, 12'h000, 32'h41, 32'h0, 1'h0, 8'hF0}};
  logic [7:0] tc [4] = '{8'h58, 8'h48, 8'h50, 8'h59}; // sync mode, off, sleep
  pssm_top #(.H_LOW_CYC(200), .H_HIGH_CYC(20)) u_pssm_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tearing_sync_out(tearing_sync_out),
    .scan_addr(scan_addr), .row_addr(row_addr), .column_addr(column_addr),
    .pixel_valid(pixel_valid), .line_visible(line_visible), .rgb_swap(rgb_swap),
    .gate_lines(gate_lines));
  pssm_host_model u_pssm_host_model (.pclk(pclk), .presetn(presetn),
    .sync_in(tearing_sync_out), .slow_host(slow_host), .write_go(host_go), .pulse_cnt(pulse_cnt));
  // 200 MHz clock
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  // count rising edges of the pixel strobe, one per visible line
  always @(posedge pclk) begin
    #1;
    if (pixel_valid === 1'h1 && pv_q !== 1'h1)
      lcnt++;
    pv_q = pixel_valid;
  end
  // verdict and end of run
  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a wait that ran out
  task automatic tmo();
    error_cnt++;
    $display("Error %0t: wait ran out", $time);
    end_sim();
  endtask
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [11:0] a, input pssm_word_t d,
    output pssm_word_t rd, output logic er);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1)
        break;
    end
    if (i == 20)
      tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // register write, answer dropped
  task automatic wr(input logic [11:0] a, input pssm_word_t d);
    pssm_word_t r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  // wait for the next visible line to start its pixels
  task automatic wait_rise();
    int w;
    int i;
    w = lcnt;
    for (i = 0; i < 2000; i++) begin
      @(posedge pclk);
      #2;
      if (lcnt != w)
        break;
    end
    if (i == 2000)
      tmo();
  endtask
  // memory row expected on gate row g (240 rows, top 3, height 235, bottom 2, start 230)
  function automatic pssm_line_t exp_row(int g, bit sd, bit rm, bit sc);
    int t;
    int r;
    t = sd ? 2 : 3;
    r = g;
    if (sc && g >= t && g < t + 235) begin
      r = 230 + g - t;
      if (r >= t + 235)
        r = r - 235;
    end
    if (rm)
      r = 239 - r;
    return pssm_line_t'(r);
  endfunction
  // main sequence
  initial begin
    pssm_word_t rd;
    logic er;
    bit sd, rm, sc, cm, rg;
    int g, n;
    pssm_line_t s;
    logic [15:0] p;
    {presetn, psel, penable, pwrite, slow_host} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    // register table
    for (int i = 0; i < 13; i++) begin
      apb(rows[i].we, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].we)
        chk(rd, rows[i].x);
      chk(er, rows[i].e);
      repeat (2) @(posedge pclk);
      chk(gate_lines, rows[i].g);
    end
    // mirror, direction, colour order and scroll per line
    wr(12'h00C, 32'h0002EB03);
    wr(12'h010, 32'hE6);
    for (int i = 0; i < 6; i++) begin
      sd = i[0];
      rm = (i < 4) && i[1];
      sc = (i >= 4);
      cm = i[1];
      rg = i[0];
      wr(12'h004, {24'h0, rm, cm, 1'h0, sd, rg, 3'h0});
      wr(12'h000, sc ? 32'h44 : 32'h40);
      wait_rise();
      wait_rise();
      g = sd ? 240 - lcnt : lcnt - 1;
      chk(scan_addr, g);
      chk(row_addr, exp_row(g, sd, rm, sc));
      chk(rgb_swap, rg);
      chk(column_addr, cm ? 32'hAF : 32'h0);
      repeat (175) @(posedge pclk);
      #2;
      chk(column_addr, cm ? 32'h0 : 32'hAF);
      chk(pixel_valid, 1'h1);
      @(posedge pclk);
      #2;
      chk(pixel_valid, 1'h0);
    end
    // partial window of a single line
    wr(12'h004, 32'h0);
    s = pssm_line_t'(lcnt + 3);
    wr(12'h008, {16'h0, s, s});
    wr(12'h000, 32'h42);
    wait_rise();
    chk(scan_addr, s);
    chk(line_visible, 1'h1);
    repeat (240) @(posedge pclk);
    chk(line_visible, 1'h0);
    // sync output per mode, disabled and in sleep
    for (int j = 0; j < 4; j++) begin
      wr(12'h000, {24'h0, tc[j]});
      wait_rise();
      wait_rise();
      p = pulse_cnt;
      chk(tearing_sync_out, 1'h0);
      repeat (205) @(posedge pclk);
      #2;
      chk(tearing_sync_out, j == 0);
      repeat (15) @(posedge pclk);
      chk(pulse_cnt - p, j == 0);
    end
    // vertical blanking length in mode 1, then the frame restarts at row 0
    wr(12'h000, 32'h48);
    for (n = 0; n < 60000 && tearing_sync_out !== 1'h1; n++) begin
      @(posedge pclk);
      #2;
    end
    if (n == 60000)
      tmo();
    for (n = 0; n < 5000 && tearing_sync_out === 1'h1; n++) begin
      @(posedge pclk);
      #2;
    end
    chk(n, 3520);
    chk(host_go, 1'h1);
    wait_rise();
    chk(scan_addr, 8'h00);
    // reset in mid-run restores 240 rows and a low sync
    wr(12'h000, 32'h01);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    #2;
    chk(gate_lines, 8'hF0);
    chk(tearing_sync_out, 1'h0);
    @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    #2;
    chk(pixel_valid, 1'h0);
    @(posedge pclk);
    #2;
    chk(pixel_valid, 1'h1);
    end_sim();
  end
endmodule
